// [hw/comp_params.svh]
/*
  Constants of the sensor compensation block: register map, reset values,
  field positions, fixed-point scaling and fault timing.
  Assumes inclusion by bare name from every design file that needs a figure.
*/
`ifndef COMP_PARAMS_SVH
`define COMP_PARAMS_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define R_DIAG 4'h0
`define R_CFG 4'h1
`define R_MASK 4'h2
`define R_STAT 4'h3
`define R_POFF 4'h4
`define R_PGAIN 4'h5
`define R_TOFF 4'h6
`define R_TGAIN 4'h7
`define R_FLOOR 4'h8
`define R_CEIL 4'h9
`define R_NFLOOR 4'ha
`define R_NCEIL 4'hb
`define R_FVAL 4'hc
`define R_DAC 4'hd
`define NUM_REGS 14

// ****************************************
// Reset values and writable widths
// ****************************************
`define RST_GAIN 16'h4000
`define RST_CEIL 16'h3fff
`define RST_NFLOOR 16'h0667
`define RST_NCEIL 16'h399a
`define RST_MASK 16'h00ff
`define WMASK_BYTE 16'h00ff
`define WMASK_DAC 16'h3fff

// ****************************************
// Field positions
// ****************************************
`define CFG_PULLDN_DIS_BIT 5
`define CFG_PULLUP_DIS_BIT 6
`define MASK_SPARE_BIT 3
`define FAULT_SUPPLY_BIT 8

// ****************************************
// Coefficient memory
// ****************************************
`define COEF_DEPTH 32
`define COEF_AW 5
`define IIR_BASE 5'h10
`define LAST_TSTEP 4'hf
`define LAST_PSTEP 4'h2
`define LAST_ISTEP 4'h5
`define IIR_W_STEP 4'h2
`define IIR_B0_STEP 4'h3

// ****************************************
// Arithmetic
// ****************************************
`define Q_SHIFT 14
`define DAC_MAX 14'h3fff

// ****************************************
// Temperature sensor codes at 5 V/V
// ****************************************
`define TCODE_M40 16'h16c9
`define TCODE_0 16'h1acf
`define TCODE_150 16'h29e5
`define TDEG_LO 40
`define TDEG_HI 150

// ****************************************
// Fault detection timing
// ****************************************
`define CLK_KHZ 125000
`define FAULT_TICK_MS 8
`define CONFIRM_TICKS 2'd2

`endif

// [hw/comp_pkg.sv]
/*
  Types shared by the compensation block and its coefficient memory.
  Assumes nothing of its surroundings.
*/
package comp_pkg;
  typedef logic [15:0] word_t;           // Stored coefficient or sample
  typedef logic [13:0] dac_t;            // Output DAC code
  typedef logic signed [31:0] acc_t;     // Saturating accumulator
  typedef enum logic [3:0] {
    S_IDLE, S_GAIN, S_TFETCH, S_TMAC, S_PMAC, S_CLAMP, S_IFETCH, S_IMAC, S_OUT
  } state_t;
endpackage

// [hw/coef_bus_if.sv]
/*
  Bundle between the compensation core and its coefficient memory:
  one write port and two registered read ports.
  Assumes the package is compiled first.
*/
`timescale 1ns/1ns
interface coef_bus_if;
  import comp_pkg::*;
  logic we;                      // Write strobe
  logic [4:0] waddr;             // Write index
  word_t wdata;                  // Write data
  logic [4:0] raddr_a;           // Bus read index
  logic [4:0] raddr_b;           // Datapath read index
  word_t rdata_a;                // Bus read data, one cycle late
  word_t rdata_b;                // Datapath read data, one cycle late
  modport mem (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
  modport user (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
endinterface

// [hw/coef_mem.sv]
/*
  Coefficient store: 16 polynomial words then six filter words.
  Assumes one clock; reads come out of a register one cycle after the index.
*/
`timescale 1ns/1ns
`include "comp_params.svh"
module coef_mem (
  input wire logic CLK,
  input wire logic ARST_N,
  coef_bus_if.mem bus
);
  import comp_pkg::*;

  word_t mem_r [0:`COEF_DEPTH-1]; // Storage, cleared so an empty store means no filtering

  // ****************************************
  // Storage and registered reads
  // ****************************************
  // Cleared at reset: zero coefficients give a defined, harmless output
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < `COEF_DEPTH; i++) begin
        mem_r[i] <= 16'h0000;
      end
      bus.rdata_a <= 16'h0000;
      bus.rdata_b <= 16'h0000;
    end else begin
      if (bus.we) begin
        mem_r[bus.waddr] <= bus.wdata;
      end
      bus.rdata_a <= mem_r[bus.raddr_a];
      bus.rdata_b <= mem_r[bus.raddr_b];
    end
  end
endmodule

// [hw/sensor_comp.sv]
/*
  Digital compensation path of a bridge pressure conditioner: digital gain
  and offset, 16-coefficient polynomial, clamp, second-order filter, DAC
  code, plus signal-chain fault masking and fault timing. APB slave.
  Assumes samples, fault comparator flags and error inputs are synchronous
  to CLK, and one new sample pulse per conversion.
*/
// Notes on behaviour
// - Config bit 6 disconnects thermal input pull-ups
// - Mask bit one enables, zero suppresses fault
// - Mask bits 0..2 gate input faults
// - Mask bits 4,5 gate pressure gain output
// - Mask bits 6,7 gate temperature gain output
// - Each gain stage output checked against range
// - Run-time faults flagged between 8 and 16 ms
// - Memory corruption fault evaluated only at power-up
// - Samples get offset then gain before compensation
// - Cubic in pressure, cubic-in-temperature weights, 16 coefficients
// - Offset and gain values scaled by 2^14
// - Zero higher coefficients leave offset plus gain*pressure
// - Internal sensor codes map linearly to degrees
// - Result goes through second-order IIR to DAC
// - Compensated value clamped between floor and ceiling limits before the filter
// - Separate normal band inside the clamp limits
// - Compensation errors disable DAC, hold logic reset
// - Chain faults drive fault code; corruption drives zero
// - Zero master switch disables every diagnostic
`timescale 1ns/1ns
`include "comp_params.svh"
module sensor_comp #(
  parameter int TICK_CYCLES = `FAULT_TICK_MS * `CLK_KHZ
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SAMPLE_VALID,
  input wire comp_pkg::word_t P_SAMPLE,
  input wire comp_pkg::word_t T_SAMPLE,
  input wire logic [7:0] CHAIN_FAULT,
  input wire logic SUPPLY_FAULT,
  input wire logic EE_CRC_BAD,
  input wire logic COMP_TIMING_ERR,
  input wire logic COMP_CHECKSUM_ERR,
  output comp_pkg::dac_t DAC_CODE,
  output logic DAC_EN,
  output logic DAC_STROBE,
  output logic THERM_PULLUP_DIS,
  output logic BRIDGE_PULLDOWN_DIS
);
  import comp_pkg::*;

  // ****************************************
  // Arithmetic helpers
  // ****************************************
  // Saturate a wide product sum into the accumulator range
  function automatic acc_t sat(input logic signed [63:0] v);
    if (v > 64'sh000000007fffffff) return 32'sh7fffffff;
    if (v < -64'sh0000000080000000) return -32'sh80000000;
    return acc_t'(v[31:0]);
  endfunction

  // One Horner step: c + acc*x, product optionally rescaled by 2^14
  function automatic acc_t hstep(input acc_t acc, input acc_t x, input acc_t c, input logic scale);
    logic signed [63:0] prod;
    prod = 64'(acc) * 64'(x);
    if (scale) prod = prod >>> `Q_SHIFT;
    return sat(prod + 64'(c));
  endfunction

  // Digital offset then gain, gain held as value times 2^14
  function automatic acc_t gainoff(input word_t adc, input word_t off, input word_t gain);
    logic signed [63:0] sum;
    sum = 64'(signed'(adc)) + 64'(signed'(off));
    return sat((sum * 64'(signed'(gain))) >>> `Q_SHIFT);
  endfunction

  // Limit to [lo, hi]; lo and hi are unsigned DAC codes
  function automatic dac_t clamp(input acc_t v, input word_t lo, input word_t hi);
    acc_t lo_s;
    acc_t hi_s;
    lo_s = signed'({18'h00000, lo[13:0]});
    hi_s = signed'({18'h00000, hi[13:0]});
    if (v < lo_s) return lo[13:0];
    if (v > hi_s) return hi[13:0];
    return v[13:0];
  endfunction

  // Internal sensor code to whole degrees, piecewise linear
  function automatic word_t tdeg(input word_t code);
    int c;
    int d;
    c = int'(code);
    if (c < int'(`TCODE_0)) begin
      d = ((c - int'(`TCODE_M40)) * `TDEG_LO) / int'(`TCODE_0 - `TCODE_M40) - `TDEG_LO;
    end else begin
      d = ((c - int'(`TCODE_0)) * `TDEG_HI) / int'(`TCODE_150 - `TCODE_0);
    end
    return 16'(d);
  endfunction

  // Writable bits of each control register
  function automatic word_t wmask(input logic [3:0] idx);
    case (idx)
      `R_DIAG, `R_CFG, `R_MASK: return `WMASK_BYTE;
      `R_FLOOR, `R_CEIL, `R_NFLOOR, `R_NCEIL, `R_FVAL: return `WMASK_DAC;
      `R_STAT, `R_DAC: return 16'h0000;
      default: return 16'hffff;
    endcase
  endfunction

  // Value after reset of each control register
  function automatic word_t rstval(input logic [3:0] idx);
    case (idx)
      `R_MASK: return `RST_MASK;
      `R_PGAIN, `R_TGAIN: return `RST_GAIN;
      `R_CEIL: return `RST_CEIL;
      `R_NFLOOR: return `RST_NFLOOR;
      `R_NCEIL: return `RST_NCEIL;
      default: return 16'h0000;
    endcase
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  coef_bus_if cbus ();              // Path to the coefficient store
  word_t ctl_r [0:`NUM_REGS-1];     // Control registers, word per index
  state_t st_r;                     // Datapath sequencer
  logic [3:0] cnt_r;                // Step within a phase
  acc_t acc_r;                      // Running accumulator
  acc_t p_r;                        // Pressure after gain and offset
  acc_t t_r;                        // Temperature after gain and offset
  acc_t tc_r [0:3];                 // Temperature-weighted pressure coefficients
  acc_t x_r;                        // Clamped compensated value
  acc_t w_r;                        // Filter state w(n)
  acc_t w1_r;                       // Filter state w(n-1)
  acc_t w2_r;                       // Filter state w(n-2)
  logic flt_on_r;                   // Filter active (a0 non-zero)
  dac_t comp_r;                     // Last compensated code
  word_t deg_r;                     // Last temperature in degrees
  logic below_r;                    // Result under normal band
  logic above_r;                    // Result over normal band
  logic [31:0] tick_cnt_r;          // Fault timebase divider
  logic tick_r;                     // One-cycle timebase pulse
  logic [1:0] hold_r [0:8];         // Ticks each fault has persisted
  logic ee_cap_r;                   // Power-up memory status taken
  logic ee_bad_r;                   // Memory corrupt at power-up

  // ****************************************
  // Decoding
  // ****************************************
  wire diag_on = |ctl_r[`R_DIAG][7:0];
  wire comp_err = diag_on & (COMP_TIMING_ERR | COMP_CHECKSUM_ERR);
  wire ee_act = diag_on & ee_bad_r;
  wire [3:0] ridx = PADDR[5:2];
  wire is_coef = PADDR[7];
  wire reg_hit = ~PADDR[6] & (ridx < 4'(`NUM_REGS));
  wire hit = (PADDR[1:0] == 2'b00) & (is_coef | reg_hit);
  wire access = PSEL & PENABLE;
  wire done = access & PREADY;
  wire wr_reg = done & PWRITE & hit & ~is_coef;
  // Chain comparators (gain outputs included) gated by mask; bit 3 has no fault
  wire [7:0] chain_en = ctl_r[`R_MASK][7:0] & ~(8'h01 << `MASK_SPARE_BIT);
  wire [8:0] cond = {SUPPLY_FAULT, CHAIN_FAULT & chain_en} & {9{diag_on}};
  logic [8:0] fault_vec;
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      fault_vec[i] = (hold_r[i] == `CONFIRM_TICKS);
    end
  end
  wire any_fault = |fault_vec;
  wire [31:0] status = {deg_r, 2'b00, (st_r != S_IDLE), above_r, below_r, ee_act, comp_err, fault_vec};
  wire [31:0] reg_rd = (ridx == `R_STAT) ? status :
                       (ridx == `R_DAC) ? {18'h00000, DAC_CODE} : {16'h0000, ctl_r[ridx]};
  wire [31:0] rd_mux = ~hit ? 32'h00000000 : is_coef ? {16'h0000, cbus.rdata_a} : reg_rd;
  // Datapath coefficient fetch index
  wire [4:0] t_addr = {1'b0, cnt_r[3:2], ~cnt_r[1:0]};
  wire [4:0] i_addr = `IIR_BASE + {1'b0, cnt_r};
  wire acc_t cval = acc_t'(signed'(cbus.rdata_b));
  wire acc_t tmac = (cnt_r[1:0] == 2'b00) ? cval : hstep(acc_r, t_r, cval, 1'b1);
  wire acc_t pm_in = (cnt_r == 4'h0) ? tc_r[3] : acc_r;
  wire acc_t pm_c = tc_r[2'd2 - cnt_r[1:0]];
  wire acc_t pmac = hstep(pm_in, p_r, pm_c, cnt_r != `LAST_PSTEP);
  wire acc_t i_op = (cnt_r == 4'h0) ? x_r : (cnt_r == 4'h1 || cnt_r == 4'h4) ? w1_r :
                    (cnt_r == `IIR_B0_STEP) ? w_r : w2_r;
  wire acc_t i_base = (cnt_r == 4'h0 || cnt_r == `IIR_B0_STEP) ? 32'sh0 : acc_r;
  wire acc_t imac = hstep(cval, i_op, i_base, 1'b0);
  wire acc_t iout = acc_t'(imac >>> `Q_SHIFT);
  // Filtered result is the finished accumulation; the live product is stale by then
  wire dac_t y_code = flt_on_r ? clamp(acc_t'(acc_r >>> `Q_SHIFT), 16'h0000, {2'b00, `DAC_MAX}) : x_r[13:0];

  assign cbus.we = done & PWRITE & is_coef;
  assign cbus.waddr = PADDR[6:2];
  assign cbus.wdata = PWDATA[15:0];
  assign cbus.raddr_a = PADDR[6:2];
  assign cbus.raddr_b = (st_r == S_IFETCH) ? i_addr : t_addr;

  coef_mem u_mem (
    .CLK(CLK),
    .ARST_N(ARST_N),
    .bus(cbus)
  );

  // ****************************************
  // APB slave: one wait state, answer registered
  // ****************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= access & ~PREADY;
      PRDATA <= (access & ~PREADY & ~PWRITE) ? rd_mux : 32'h00000000;
      PSLVERR <= access & ~PREADY & ~hit;    // Unmapped or misaligned
    end
  end

  // Control registers; read-only words ignore writes
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < `NUM_REGS; i++) begin
        ctl_r[i] <= rstval(4'(i));
      end
    end else if (wr_reg) begin
      ctl_r[ridx] <= PWDATA[15:0] & wmask(ridx);
    end
  end

  // ****************************************
  // Fault timing
  // ****************************************
  // Timebase: one pulse per detection period
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1)) ? 32'h00000000 : tick_cnt_r + 32'h00000001;
    end
  end

  // Two ticks of unbroken fault: more than one period, under two
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < 9; i++) begin
        hold_r[i] <= 2'b00;
      end
    end else begin
      for (int i = 0; i < 9; i++) begin
        if (!cond[i]) begin
          hold_r[i] <= 2'b00;
        end else if (tick_r && hold_r[i] != `CONFIRM_TICKS) begin
          hold_r[i] <= hold_r[i] + 2'b01;
        end
      end
    end
  end

  // Memory status is only meaningful once, right after power-up
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ee_cap_r <= 1'b0;
      ee_bad_r <= 1'b0;
    end else if (!ee_cap_r) begin
      ee_cap_r <= 1'b1;
      ee_bad_r <= EE_CRC_BAD;
    end
  end

  // ****************************************
  // Compensation sequencer
  // ****************************************
  // Samples arriving while busy are dropped: one result per accepted sample
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r <= S_IDLE;
      cnt_r <= 4'h0;
      acc_r <= 32'sh0;
      p_r <= 32'sh0;
      t_r <= 32'sh0;
      x_r <= 32'sh0;
      w_r <= 32'sh0;
      w1_r <= 32'sh0;
      w2_r <= 32'sh0;
      flt_on_r <= 1'b0;
      comp_r <= 14'h0000;
      deg_r <= 16'h0000;
      below_r <= 1'b0;
      above_r <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        tc_r[i] <= 32'sh0;
      end
    end else if (comp_err) begin
      // Held in reset while the error stands
      st_r <= S_IDLE;
      cnt_r <= 4'h0;
      w1_r <= 32'sh0;
      w2_r <= 32'sh0;
    end else begin
      case (st_r)
        S_IDLE: begin
          if (SAMPLE_VALID) begin
            p_r <= acc_t'(signed'(P_SAMPLE));
            t_r <= acc_t'(signed'(T_SAMPLE));
            deg_r <= tdeg(T_SAMPLE);
            st_r <= S_GAIN;
          end
        end
        S_GAIN: begin
          p_r <= gainoff(p_r[15:0], ctl_r[`R_POFF], ctl_r[`R_PGAIN]);
          t_r <= gainoff(t_r[15:0], ctl_r[`R_TOFF], ctl_r[`R_TGAIN]);
          cnt_r <= 4'h0;
          st_r <= S_TFETCH;
        end
        S_TFETCH: st_r <= S_TMAC;
        S_TMAC: begin
          acc_r <= tmac;
          if (cnt_r[1:0] == 2'b11) begin
            tc_r[cnt_r[3:2]] <= tmac;
          end
          cnt_r <= (cnt_r == `LAST_TSTEP) ? 4'h0 : cnt_r + 4'h1;
          st_r <= (cnt_r == `LAST_TSTEP) ? S_PMAC : S_TFETCH;
        end
        S_PMAC: begin
          acc_r <= pmac;
          cnt_r <= (cnt_r == `LAST_PSTEP) ? 4'h0 : cnt_r + 4'h1;
          st_r <= (cnt_r == `LAST_PSTEP) ? S_CLAMP : S_PMAC;
        end
        S_CLAMP: begin
          x_r <= signed'({18'h00000, clamp(acc_r >>> `Q_SHIFT, ctl_r[`R_FLOOR], ctl_r[`R_CEIL])});
          st_r <= S_IFETCH;
        end
        S_IFETCH: st_r <= S_IMAC;
        S_IMAC: begin
          acc_r <= imac;
          if (cnt_r == 4'h0) begin
            flt_on_r <= (cbus.rdata_b != 16'h0000);  // Zero a0 bypasses filter
          end
          if (cnt_r == `IIR_W_STEP) begin
            w_r <= iout;
          end
          cnt_r <= (cnt_r == `LAST_ISTEP) ? 4'h0 : cnt_r + 4'h1;
          st_r <= (cnt_r == `LAST_ISTEP) ? S_OUT : S_IFETCH;
        end
        S_OUT: begin
          comp_r <= y_code;
          below_r <= {2'b00, y_code} < ctl_r[`R_NFLOOR];
          above_r <= {2'b00, y_code} > ctl_r[`R_NCEIL];
          if (flt_on_r) begin
            w2_r <= w1_r;
            w1_r <= w_r;
          end
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Fault codes override the compensated value every cycle, not per sample
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DAC_CODE <= 14'h0000;
      DAC_EN <= 1'b0;
      DAC_STROBE <= 1'b0;
      THERM_PULLUP_DIS <= 1'b0;
      BRIDGE_PULLDOWN_DIS <= 1'b0;
    end else begin
      DAC_EN <= ~comp_err;
      DAC_STROBE <= (st_r == S_OUT) & ~comp_err;
      DAC_CODE <= ee_act ? 14'h0000 : any_fault ? ctl_r[`R_FVAL][13:0] :
                  (st_r == S_OUT) ? y_code : comp_r;
      THERM_PULLUP_DIS <= ctl_r[`R_CFG][`CFG_PULLUP_DIS_BIT];
      BRIDGE_PULLDOWN_DIS <= ctl_r[`R_CFG][`CFG_PULLDN_DIS_BIT];
    end
  end
endmodule

// [bench/sensor_comp_asserts.sv]
/* Port checker for sensor_comp, bound to every instance.
   Assumes APB and sample lines are synchronous to CLK. */
`timescale 1ns/1ns
module sensor_comp_asserts (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SAMPLE_VALID,
  input wire logic DAC_EN,
  input wire logic DAC_STROBE,
  input wire logic THERM_PULLUP_DIS
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  wire cfg_wr = PSEL && PENABLE && PWRITE && PREADY && PADDR == 8'h04; // Config write lands
  wire bad_a = PADDR[1:0] != 2'h0 || (PADDR >= 8'h38 && PADDR < 8'h80); // Unmapped place
  AST_READY_PULSE: assert property (PREADY |=> !PREADY) else $error("ready over one cycle");
  AST_READY_ACCESS: assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
  AST_ERR_READY: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  AST_RDATA_IDLE: assert property (!PREADY |-> PRDATA == 32'h0) else $error("read data off answer");
  AST_UNMAPPED: assert property (PREADY && bad_a |-> PSLVERR) else $error("unmapped not refused");
  AST_PULLUP: assert property (cfg_wr |-> ##2 THERM_PULLUP_DIS == $past(PWDATA[6], 2))
    else $error("pull-up control wrong");
  AST_STROBE_PULSE: assert property (DAC_STROBE |=> !DAC_STROBE) else $error("strobe too long");
  // Result only a fixed time after a taken sample
  AST_STROBE_LAT: assert property (DAC_STROBE |-> $past(SAMPLE_VALID, 51))
    else $error("strobe without sample");
  AST_HOLD_ERR: assert property (!DAC_EN |-> !DAC_STROBE) else $error("result while held");
  cover property (cfg_wr);
  cover property (PREADY && PSLVERR);
  cover property (DAC_STROBE);
endmodule
bind sensor_comp sensor_comp_asserts i_sensor_comp_asserts (.CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PRDATA, .PREADY, .PSLVERR, .SAMPLE_VALID, .DAC_EN, .DAC_STROBE, .THERM_PULLUP_DIS);

// [bench/adc_model.sv]
/* Upstream converter model: one pressure and temperature pair per request.
   Assumes requests come from the bench, one per conversion. */
`timescale 1ns/1ns
module adc_model (
  input wire logic clk,
  input wire logic go,
  input wire comp_pkg::word_t p_in,
  output logic sample_valid,
  output comp_pkg::word_t p_sample,
  output comp_pkg::word_t t_sample
);
  import comp_pkg::*;
  initial begin
    sample_valid = 1'b0;
    p_sample = 16'h0;
    t_sample = 16'h0;
  end
  // Valid for one cycle; data then inverted so no stale value passes
  always @(posedge clk) begin
    sample_valid <= go;
    p_sample <= go ? p_in : ~p_sample;
    t_sample <= go ? 16'h1acf : ~t_sample;
  end
endmodule

// [bench/tb_top.sv]
/* Self-checking bench for sensor_comp: APB master, converter model, faults.
   Assumes design files and checker are compiled first. */
`timescale 1ns/1ns
module tb_top;
  import comp_pkg::*;
  localparam int TK = 20; // Shortened fault tick
  logic CLK = 1'b0, ARST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, go = 1'b0;
  logic [7:0] PADDR = 8'h0, CHAIN_FAULT = 8'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic SUPPLY_FAULT = 1'b0, EE_CRC_BAD = 1'b0, COMP_TIMING_ERR = 1'b0, COMP_CHECKSUM_ERR = 1'b0;
  logic PREADY, PSLVERR, SAMPLE_VALID, DAC_EN, DAC_STROBE, THERM_PULLUP_DIS, BRIDGE_PULLDOWN_DIS, er;
  word_t P_SAMPLE, T_SAMPLE, p_in = 16'h0;
  dac_t DAC_CODE;
  int n_fail = 0, num_checks = 0, cyc = 0;
  // Rows: h0, g0, floor, ceiling, P offset, P gain, sample; then result
  logic [7:0] radr [6] = '{8'h80, 8'h90, 8'h20, 8'h24, 8'h10, 8'h14};
  logic [15:0] rows [7][7] = '{'{0, 16'h2000, 0, 16'h3fff, 0, 16'h4000, 16'h4000},
    '{16'h4000, 16'h4000, 0, 16'h3fff, 0, 16'h4000, 16'h1000}, '{0, 16'h4000, 0, 16'h3fff, 0, 16'h4000, 16'hf000},
    '{0, 16'h4000, 0, 16'h3fff, 0, 16'h4000, 16'h7fff}, '{0, 16'h4000, 16'h100, 16'h200, 0, 16'h4000, 16'h50},
    '{0, 16'h4000, 16'h100, 16'h200, 0, 16'h4000, 16'h1000}, '{0, 16'h4000, 0, 16'h3fff, 16'h100, 16'h2000, 16'hf00}};
  logic [13:0] rexp [7] = '{14'h2000, 14'h1001, 14'h0, 14'h3fff, 14'h100, 14'h200, 14'h800};
  always #4 CLK = ~CLK;
  sensor_comp #(.TICK_CYCLES(TK)) i_sensor_comp (.CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .SAMPLE_VALID, .P_SAMPLE, .T_SAMPLE, .CHAIN_FAULT, .SUPPLY_FAULT, .EE_CRC_BAD,
    .COMP_TIMING_ERR, .COMP_CHECKSUM_ERR, .DAC_CODE, .DAC_EN, .DAC_STROBE, .THERM_PULLUP_DIS, .BRIDGE_PULLDOWN_DIS);
  adc_model i_adc_model (.clk(CLK), .go, .p_in, .sample_valid(SAMPLE_VALID), .p_sample(P_SAMPLE),
    .t_sample(T_SAMPLE));
  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; holds everything until ready is sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(negedge CLK);
  endtask
  task automatic rdk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rd, e);
  endtask
  // Sample request; the result strobe is looked for in a bounded window
  task automatic smp(input logic [15:0] p, input logic e);
    int n;
    logic s;
    n = 0;
    @(posedge CLK);
    go <= 1'b1;
    p_in <= p;
    @(posedge CLK);
    go <= 1'b0;
    do @(posedge CLK); while (DAC_STROBE !== 1'b1 && ++n < 70);
    s = (DAC_STROBE === 1'b1);
    @(negedge CLK);
    chk("strobe", s, e);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (8) @(posedge CLK);
    ARST_N <= 1'b1;
    rdk(8'h08, 32'hff);
    rdk(8'h28, 32'h667);
    rdk(8'h2c, 32'h399a);
    rdk(8'h14, 32'h4000);
    for (int i = 0; i < 7; i++) begin
      // Floor raised to 0x100 in rows 4 and 5 to hit the clamp; higher terms stay zero
      for (int j = 0; j < 6; j++) apb(1'b1, radr[j], {16'h0, rows[i][j]});
      smp(rows[i][6], 1'b1);
      chk("dac_code", DAC_CODE, rexp[i]);
    end
    apb(1'b1, 8'h04, 32'h40);
    @(negedge CLK);
    chk("pullup", THERM_PULLUP_DIS, 1);
    apb(1'b1, 8'h04, 32'h20);
    @(negedge CLK);
    chk("pullup", THERM_PULLUP_DIS, 0);
    chk("pulldown", BRIDGE_PULLDOWN_DIS, 1);
    apb(1'b0, 8'h38, 32'h0);
    chk("slverr", er, 1);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h30, 32'h1234);
    // Each mask bit alone; bit 3 has no fault behind it
    for (int b = 0; b < 8; b++) begin
      @(posedge CLK);
      CHAIN_FAULT <= 8'h1 << b;
      repeat (TK - 6) @(posedge CLK);
      rdk(8'h0c, 32'h0);
      repeat (TK + 4) @(posedge CLK);
      apb(1'b0, 8'h0c, 32'h0);
      chk("status", rd[8:0], b == 3 ? 0 : 1 << b);
      if (b != 3) chk("fault_code", DAC_CODE, 14'h1234);
      @(posedge CLK);
      CHAIN_FAULT <= 8'h0;
    end
    apb(1'b1, 8'h08, 32'hef);
    apb(1'b1, 8'h00, 32'h0);
    @(posedge CLK);
    CHAIN_FAULT <= 8'h11;
    SUPPLY_FAULT <= 1'b1;
    COMP_TIMING_ERR <= 1'b1;
    repeat (3 * TK) @(posedge CLK);
    apb(1'b0, 8'h0c, 32'h0);
    chk("diag_off", rd[9:0], 0);
    chk("dac_en", DAC_EN, 1);
    apb(1'b1, 8'h00, 32'h1);
    repeat (2 * TK + 4) @(posedge CLK);
    apb(1'b0, 8'h0c, 32'h0);
    chk("masked", rd[8:0], 9'h101);
    chk("dac_en", DAC_EN, 0);
    @(posedge CLK);
    CHAIN_FAULT <= 8'h0;
    SUPPLY_FAULT <= 1'b0;
    COMP_TIMING_ERR <= 1'b0;
    COMP_CHECKSUM_ERR <= 1'b1;
    smp(16'h1000, 1'b0);
    chk("dac_en", DAC_EN, 0);
    @(posedge CLK);
    COMP_CHECKSUM_ERR <= 1'b0;
    smp(16'h1000, 1'b1);
    chk("restart", DAC_CODE, 14'h880);
    // Filter on: a0 unity, b0 one half, history cleared by the error
    apb(1'b1, 8'hc0, 32'h4000);
    apb(1'b1, 8'hcc, 32'h2000);
    smp(16'h1000, 1'b1);
    chk("filtered", DAC_CODE, 14'h440);
    // Second reset with a bad memory flag, dropped right after capture
    @(posedge CLK);
    EE_CRC_BAD <= 1'b1;
    ARST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    chk("rst_code", DAC_CODE, 0);
    ARST_N <= 1'b1;
    @(posedge CLK);
    EE_CRC_BAD <= 1'b0;
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h90, 32'h4000);
    smp(16'h1000, 1'b1);
    chk("ee_code", DAC_CODE, 0);
    apb(1'b0, 8'h0c, 32'h0);
    chk("ee_bad", rd[10], 1);
    end_of_test();
  end
endmodule
